// ### src/pfac_pkg.sv
// Function
// - Flash reached only through seven registers
// - Data pair forms one 14-bit word
// - Address pair forms one flash address
// - Flash array holds 8k words, only 0000h to 0FFFh addressable
// - Single-word reads, four-word writes only
// - Four-word write erases row first
// - Write time set by internal timer
// - Code protect still allows CPU access
// - Protected blocks refuse writes, reads allowed
// - Code protect denies serial programmer access
// - Triggers set-only, hardware clears on completion
// - Write needs permit bit, cleared at reset
// - Calibration select reads test area
// - Calibration select blocks any write
// - Unlock port reads as zero
// - Unlock port used only for writes
// - Data high bits 5-0, 7-6 read zero
// - Address high bits 3-0, 7-4 read zero
// - Low registers eight bits, reset zero
// - Read uses second cycle, data next cycle
// - Write block four aligned words
// - Control bits: cal 6, permit 2, wr 1, rd 0
package pfac_pkg;
    localparam logic [11:0] CTRL_OFF   = 12'h000;
    localparam logic [11:0] UNLOCK_OFF = 12'h004;
    localparam logic [11:0] DATL_OFF   = 12'h008;
    localparam logic [11:0] DATH_OFF   = 12'h00c;
    localparam logic [11:0] ADRL_OFF   = 12'h010;
    localparam logic [11:0] ADRH_OFF   = 12'h014;
    localparam logic [11:0] STAT_OFF   = 12'h018;
    localparam int CAL_BIT    = 6;
    localparam int PERMIT_BIT = 2;
    localparam int WR_BIT     = 1;
    localparam int RD_BIT     = 0;
    localparam int DATA_W     = 14;
    localparam int ADDR_W     = 13;
    localparam logic [7:0] KEY1       = 8'h55;
    localparam logic [7:0] KEY2       = 8'haa;
    localparam logic [5:0] DATH_MASK  = 6'h3f;
    localparam logic [3:0] ADRH_MASK  = 4'hf;
    localparam logic [1:0] WORDS_BLK  = 2'h3;
    localparam int WRITE_TIME_US      = 2;
    localparam int CLK_MHZ            = 100;
    localparam logic [15:0] WRITE_CYCLES = 16'(WRITE_TIME_US * CLK_MHZ);
    localparam logic [1:0] RD_WAIT    = 2'h1;
    localparam int CAL_WORDS          = 16;
    localparam logic [13:0] CAL_SEED  = 14'h2a5c;
    typedef enum logic [2:0] {
        PFAC_IDLE  = 3'b000,
        PFAC_RD1   = 3'b001,
        PFAC_RD2   = 3'b010,
        PFAC_ERASE = 3'b011,
        PFAC_PROG  = 3'b100
    } pfac_state_t;
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              we;
        logic              er;
        logic              cal;
    } pfac_flash_req_t;
endpackage

// ### src/pfac_top.sv
`timescale 1ns/1ns
module pfac_top
(
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          ce,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [11:0]                   paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [1:0]                    block_write_protect,
    input  wire logic                          code_protect_setting,
    input  wire logic                          prog_req,
    output logic                               prog_allow,
    output logic                               busy
);
    // ****************************************
    // Registers and flash array
    // ****************************************
    logic [7:0]                 dat_l_reg;
    logic [5:0]                 dat_h_reg;
    logic [7:0]                 adr_l_reg;
    logic [3:0]                 adr_h_reg;
    logic                       cal_reg;
    logic                       permit_reg;
    logic                       wr_reg;
    logic                       rd_reg;
    logic [1:0]                 key_reg;
    logic                       refused_reg;
    logic [15:0]                tmr_reg;
    logic [1:0]                 widx_reg;
    pfac_pkg::pfac_state_t      st_reg;
    logic [31:0]                prdata_reg;
    logic                       pready_reg;
    logic                       pslverr_reg;
    logic                       allow_reg;
    logic                       busy_reg;
    logic                       req_s1_reg;
    logic                       req_s2_reg;
    logic [pfac_pkg::DATA_W-1:0] user_mem [0:8191];
    logic [pfac_pkg::DATA_W-1:0] cal_mem [0:15];
    logic [pfac_pkg::DATA_W-1:0] rd_word;

    // ****************************************
    // Decode
    // ****************************************
    wire        acc      = psel && !pready_reg && ce;
    wire        wr_acc   = acc && pwrite;
    wire        sel_ctrl = paddr == pfac_pkg::CTRL_OFF;
    wire        sel_unl  = paddr == pfac_pkg::UNLOCK_OFF;
    wire        sel_datl = paddr == pfac_pkg::DATL_OFF;
    wire        sel_dath = paddr == pfac_pkg::DATH_OFF;
    wire        sel_adrl = paddr == pfac_pkg::ADRL_OFF;
    wire        sel_adrh = paddr == pfac_pkg::ADRH_OFF;
    wire        sel_stat = paddr == pfac_pkg::STAT_OFF;
    wire        mapped   = sel_ctrl | sel_unl | sel_datl | sel_dath | sel_adrl | sel_adrh
                           | sel_stat;
    wire [12:0] flash_addr = {1'b0, adr_h_reg, adr_l_reg};
    wire [13:0] flash_data = {dat_h_reg, dat_l_reg};
    wire        idle     = st_reg == pfac_pkg::PFAC_IDLE;
    wire        unlocked = key_reg == 2'h2;
    wire        ctrl_wr  = wr_acc && sel_ctrl;
    wire        set_rd   = ctrl_wr && pwdata[pfac_pkg::RD_BIT] && idle;
    wire        set_wr   = ctrl_wr && pwdata[pfac_pkg::WR_BIT] && idle && unlocked;
    wire        protected_blk;
    wire        wr_ok    = permit_reg && !cal_reg && !protected_blk;
    wire [12:0] blk_base = {flash_addr[12:2], 2'b00};

    function automatic logic blk_prot(input logic [1:0] wp, input logic [12:0] a);
        case (wp)
            2'b11:   blk_prot = 1'b0;
            2'b10:   blk_prot = a[12:10] == 3'h0;
            2'b01:   blk_prot = a[12:11] == 2'h0;
            default: blk_prot = 1'b1;
        endcase
    endfunction
    assign protected_blk = blk_prot(block_write_protect, flash_addr);
    wire [31:0] ctrl_rd = {25'h0, cal_reg, 3'h0, permit_reg, wr_reg, rd_reg};
    wire [31:0] rd_mux  = sel_ctrl ? ctrl_rd
                        : sel_unl  ? 32'h0
                        : sel_datl ? {24'h0, dat_l_reg}
                        : sel_dath ? {26'h0, dat_h_reg}
                        : sel_adrl ? {24'h0, adr_l_reg}
                        : sel_adrh ? {28'h0, adr_h_reg}
                        : sel_stat ? {30'h0, refused_reg, busy_reg}
                        : 32'h0;
    assign rd_word = cal_reg ? cal_mem[flash_addr[3:0]] : user_mem[flash_addr];

    // ****************************************
    // Calibration words
    // ****************************************
    for (genvar g = 0; g < pfac_pkg::CAL_WORDS; g++)
    begin : g_cal
        assign cal_mem[g] = pfac_pkg::CAL_SEED ^ 14'(g);
    end

    // ****************************************
    // APB slave
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else if (ce)
        begin
            pready_reg  <= acc;
            pslverr_reg <= acc && !mapped;
            prdata_reg  <= (acc && !pwrite) ? rd_mux : prdata_reg;
        end
        else
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end

    // ****************************************
    // Data and address registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adr_l_reg <= 8'h0;
            adr_h_reg <= 4'h0;
        end
        else if (ce && wr_acc && idle)
        begin
            if (sel_adrl)
                adr_l_reg <= pwdata[7:0];
            if (sel_adrh)
                adr_h_reg <= pwdata[3:0] & pfac_pkg::ADRH_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dat_l_reg <= 8'h0;
            dat_h_reg <= 6'h0;
        end
        else if (ce)
        begin
            if (st_reg == pfac_pkg::PFAC_RD2)
            begin
                dat_l_reg <= rd_word[7:0];
                dat_h_reg <= rd_word[13:8];
            end
            else if (wr_acc && idle && sel_datl)
                dat_l_reg <= pwdata[7:0];
            else if (wr_acc && idle && sel_dath)
                dat_h_reg <= pwdata[5:0] & pfac_pkg::DATH_MASK;
        end
    end

    // ****************************************
    // Control and unlock
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_reg    <= 1'b0;
            permit_reg <= 1'b0;
            key_reg    <= 2'h0;
        end
        else if (ce && wr_acc)
        begin
            if (sel_ctrl)
            begin
                cal_reg    <= pwdata[pfac_pkg::CAL_BIT];
                permit_reg <= pwdata[pfac_pkg::PERMIT_BIT];
                key_reg    <= 2'h0;
            end
            else if (sel_unl)
            begin
                if (pwdata[7:0] == pfac_pkg::KEY1)
                    key_reg <= 2'h1;
                else if (pwdata[7:0] == pfac_pkg::KEY2 && key_reg == 2'h1)
                    key_reg <= 2'h2;
                else
                    key_reg <= 2'h0;
            end
            else
                key_reg <= 2'h0;
        end
    end

    // ****************************************
    // Sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg      <= pfac_pkg::PFAC_IDLE;
            rd_reg      <= 1'b0;
            wr_reg      <= 1'b0;
            refused_reg <= 1'b0;
            tmr_reg     <= 16'h0;
            widx_reg    <= 2'h0;
            busy_reg    <= 1'b0;
        end
        else if (ce)
        begin
            case (st_reg)
                pfac_pkg::PFAC_IDLE:
                begin
                    if (set_rd)
                    begin
                        rd_reg <= 1'b1;
                        st_reg <= pfac_pkg::PFAC_RD1;
                    end
                    else if (set_wr && wr_ok)
                    begin
                        wr_reg   <= 1'b1;
                        busy_reg <= 1'b1;
                        tmr_reg  <= pfac_pkg::WRITE_CYCLES;
                        st_reg   <= pfac_pkg::PFAC_ERASE;
                    end
                    else if (set_wr)
                        refused_reg <= 1'b1;
                    else if (ctrl_wr)
                        refused_reg <= 1'b0;
                end
                pfac_pkg::PFAC_RD1:
                    st_reg <= pfac_pkg::PFAC_RD2;
                pfac_pkg::PFAC_RD2:
                begin
                    rd_reg <= 1'b0;
                    st_reg <= pfac_pkg::PFAC_IDLE;
                end
                pfac_pkg::PFAC_ERASE:
                begin
                    if (tmr_reg == 16'h1)
                    begin
                        tmr_reg  <= pfac_pkg::WRITE_CYCLES;
                        widx_reg <= 2'h0;
                        st_reg   <= pfac_pkg::PFAC_PROG;
                    end
                    else
                        tmr_reg <= tmr_reg - 16'h1;
                end
                pfac_pkg::PFAC_PROG:
                begin
                    if (tmr_reg != 16'h1)
                        tmr_reg <= tmr_reg - 16'h1;
                    else if (widx_reg == pfac_pkg::WORDS_BLK)
                    begin
                        wr_reg   <= 1'b0;
                        busy_reg <= 1'b0;
                        st_reg   <= pfac_pkg::PFAC_IDLE;
                    end
                    else
                    begin
                        tmr_reg  <= pfac_pkg::WRITE_CYCLES;
                        widx_reg <= widx_reg + 2'h1;
                    end
                end
                default:
                    st_reg <= pfac_pkg::PFAC_IDLE;
            endcase
        end
    end

    // ****************************************
    // Flash array update
    // ****************************************
    always_ff @(posedge pclk)
    begin
        if (ce && st_reg == pfac_pkg::PFAC_PROG && tmr_reg == 16'h1)
            user_mem[blk_base | {11'h0, widx_reg}] <= flash_data;
    end

    // ****************************************
    // Serial programmer gate
    // ****************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            allow_reg  <= 1'b0;
        end
        else if (ce)
        begin
            req_s1_reg <= prog_req;
            req_s2_reg <= req_s1_reg;
            allow_reg  <= req_s2_reg && !code_protect_setting;
        end
    end

    assign prdata     = prdata_reg;
    assign pready     = pready_reg;
    assign pslverr    = pslverr_reg;
    assign prog_allow = allow_reg;
    assign busy       = busy_reg;

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_rd_start;
        set_rd && ce;
    endsequence
    a_rd_two_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        s_rd_start ##1 ce ##1 ce |=> !rd_reg && idle)
        else $error("read did not finish in two cycles");
    a_rd_clears: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(rd_reg) |-> $past(st_reg) == pfac_pkg::PFAC_RD2)
        else $error("read trigger cleared early");
    a_no_permit: assert property (@(posedge pclk) disable iff (!presetn)
        set_wr && !permit_reg |=> !wr_reg && idle)
        else $error("write started without permit");
    a_cal_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        set_wr && cal_reg |=> idle)
        else $error("write started with calibration select");
    a_unlock_zero: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && sel_unl |=> prdata == 32'h0)
        else $error("unlock port read nonzero");
    a_dath_upper: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && sel_dath |=> prdata[31:6] == 26'h0)
        else $error("data high upper bits nonzero");
    a_adrh_upper: assert property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && sel_adrh |=> prdata[31:4] == 28'h0)
        else $error("address high upper bits nonzero");
    a_wr_starts: assert property (@(posedge pclk) disable iff (!presetn)
        ce && set_wr && wr_ok |=> st_reg == pfac_pkg::PFAC_ERASE && wr_reg)
        else $error("permitted write did not start erase");
    a_prog_gate: assert property (@(posedge pclk) disable iff (!presetn)
        prog_allow |-> !$past(code_protect_setting))
        else $error("programmer allowed under code protect");
    a_ce_freeze: assert property (@(posedge pclk) disable iff (!presetn)
        !ce |=> $stable(st_reg) && $stable(tmr_reg))
        else $error("state moved while clock enable low");
endmodule // pfac_top

// ### verification/pfac_prog_model.sv
`timescale 1ns/1ns
// ****************
// Serial programmer request model
// ****************
module pfac_prog_model
(
    input  wire logic pclk,
    input  wire logic want,
    output logic      prog_req
);
    // Request level moves just after a clock edge
    always @(posedge pclk)
    begin
        prog_req <= want;
    end
endmodule // pfac_prog_model

// ### verification/pfac_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) \
        begin \
            num_errors++; \
            $display("[ERR] %s expected %h seen %h", nm, e, g); \
        end \
    end
module pfac_tb_top;
    logic        pclk;
    logic        presetn;
    logic        ce;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  wp;
    logic        cprot;
    logic        want;
    logic        prog_req;
    logic        prog_allow;
    logic        busy;
    logic [31:0] rd;
    logic        er;
    logic [13:0] d0;
    logic [13:0] d1;
    logic [13:0] got;
    logic [11:0] a;
    int          num_errors;
    int          num_checks;
    int          busy_cnt;

    // ****************
    // Design and partner
    // ****************
    pfac_top pfac_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .block_write_protect(wp), .code_protect_setting(cprot), .prog_req(prog_req),
        .prog_allow(prog_allow), .busy(busy));
    pfac_prog_model pfac_prog_model_i (.pclk(pclk), .want(want), .prog_req(prog_req));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (busy === 1'b1)
            busy_cnt <= busy_cnt + 1;
    end

    // ****************
    // Bus and flash tasks
    // ****************
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        `CHK("pready", 1'b1, pready)
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [7:0] v);
        apb(1'b1, ad, {24'h0, v});
    endtask
    task automatic rr(input logic [11:0] ad);
        apb(1'b0, ad, 32'h0);
    endtask
    task automatic set_addr(input logic [11:0] ad);
        wr(pfac_pkg::ADRH_OFF, {4'h0, ad[11:8]});
        wr(pfac_pkg::ADRL_OFF, ad[7:0]);
    endtask
    task automatic flash_rd(input logic [11:0] ad, input logic [7:0] ctl);
        set_addr(ad);
        wr(pfac_pkg::CTRL_OFF, ctl | (8'h01 << pfac_pkg::RD_BIT));
        rr(pfac_pkg::CTRL_OFF);
        `CHK("rd_clear", 1'b0, rd[pfac_pkg::RD_BIT])
        rr(pfac_pkg::DATL_OFF);
        got[7:0] = rd[7:0];
        rr(pfac_pkg::DATH_OFF);
        got[13:8] = rd[5:0];
    endtask
    task automatic flash_wr(input logic [11:0] ad, input logic [13:0] d,
                            input logic [7:0] ctl, input logic acc, input logic brk);
        int b0;
        int n;
        set_addr(ad);
        wr(pfac_pkg::CTRL_OFF, ctl);
        wr(pfac_pkg::DATL_OFF, d[7:0]);
        wr(pfac_pkg::DATH_OFF, {2'b00, d[13:8]});
        wr(pfac_pkg::UNLOCK_OFF, pfac_pkg::KEY1);
        if (brk)
            wr(pfac_pkg::DATL_OFF, d[7:0]);
        wr(pfac_pkg::UNLOCK_OFF, pfac_pkg::KEY2);
        b0 = busy_cnt;
        wr(pfac_pkg::CTRL_OFF, ctl | (8'h01 << pfac_pkg::WR_BIT));
        if (acc)
        begin
            wr(pfac_pkg::CTRL_OFF, ctl);
            rr(pfac_pkg::CTRL_OFF);
            `CHK("wr_held", 1'b1, rd[pfac_pkg::WR_BIT])
        end
        n = 0;
        do
        begin
            rr(pfac_pkg::CTRL_OFF);
            n++;
        end
        while (rd[pfac_pkg::WR_BIT] !== 1'b0 && n < 700);
        `CHK("wr_clear", 1'b0, rd[pfac_pkg::WR_BIT])
        n = busy_cnt - b0;
        b0 = 5 * int'(pfac_pkg::WRITE_CYCLES);
        `CHK("busy_len", acc, (n >= b0 - 2 && n <= b0 + 4))
        rr(pfac_pkg::STAT_OFF);
        if (!brk)
            `CHK("refused", !acc, rd[1])
    endtask
    function automatic logic prot(input logic [1:0] c, input logic [11:0] ad);
        prot = (c == 2'b00) || (c == 2'b01 && ad < 12'h800) || (c == 2'b10 && ad < 12'h400);
    endfunction
    function automatic logic [13:0] cal_word(input logic [3:0] i);
        cal_word = pfac_pkg::CAL_SEED ^ {10'h0, i};
    endfunction
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************
    // Tests
    // ****************
    initial
    begin
        repeat (40000) @(posedge pclk);
        num_errors++;
        print_verdict();
    end
    initial
    begin
        logic [11:0] offs [7];
        offs = '{pfac_pkg::CTRL_OFF, pfac_pkg::UNLOCK_OFF, pfac_pkg::DATL_OFF,
                 pfac_pkg::DATH_OFF, pfac_pkg::ADRL_OFF, pfac_pkg::ADRH_OFF,
                 pfac_pkg::STAT_OFF};
        {presetn, ce, psel, penable, pwrite, cprot, want} = 7'b0100000;
        paddr = 12'h0;
        pwdata = 32'h0;
        wp = 2'b11;
        num_errors = 0;
        num_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        void'($urandom(32'h06bdf743));
        foreach (offs[i])
        begin
            rr(offs[i]);
            `CHK("reset_val", 32'h0, rd)
        end
        rr(12'h01c);
        `CHK("unmapped_err", 1'b1, er)
        d0 = 14'($urandom);
        fork
            wr(pfac_pkg::DATL_OFF, d0[7:0]);
            begin
                @(posedge pclk);
                ce <= 1'b0;
                repeat (4) @(posedge pclk);
                ce <= 1'b1;
            end
        join
        wr(pfac_pkg::ADRL_OFF, ~d0[7:0]);
        wr(pfac_pkg::DATH_OFF, 8'($urandom) | 8'hc0);
        wr(pfac_pkg::ADRH_OFF, 8'($urandom) | 8'hf0);
        wr(pfac_pkg::UNLOCK_OFF, pfac_pkg::KEY1);
        rr(pfac_pkg::UNLOCK_OFF);
        `CHK("unlock_read", 32'h0, rd)
        rr(pfac_pkg::DATL_OFF);
        `CHK("datl", {24'h0, d0[7:0]}, rd)
        rr(pfac_pkg::ADRL_OFF);
        `CHK("adrl", {24'h0, ~d0[7:0]}, rd)
        rr(pfac_pkg::DATH_OFF);
        `CHK("dath_top", 2'b00, rd[7:6])
        rr(pfac_pkg::ADRH_OFF);
        `CHK("adrh_top", 4'h0, rd[7:4])
        d0 = 14'($urandom);
        d1 = 14'($urandom);
        flash_wr(12'h810, d0, 8'h04, 1'b1, 1'b0);
        flash_wr(12'h803, d1, 8'h04, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            flash_rd(12'h800 + 12'(i), 8'h04);
            `CHK("block_word", d1, got)
        end
        flash_rd(12'h810, 8'h04);
        `CHK("other_block", d0, got)
        flash_wr(12'h800, ~d1, 8'h00, 1'b0, 1'b0);
        flash_wr(12'h800, ~d1, 8'h44, 1'b0, 1'b0);
        flash_wr(12'h800, ~d1, 8'h04, 1'b0, 1'b1);
        a = 12'h800 | 12'($urandom & 32'hf);
        flash_rd(a, 8'h44);
        `CHK("cal_read", cal_word(a[3:0]), got)
        flash_rd(12'h800, 8'h04);
        `CHK("no_write", d1, got)
        for (int c = 0; c < 4; c++)
        begin
            @(posedge pclk);
            wp <= 2'(c);
            for (int k = 0; k < 2; k++)
            begin
                a = (k == 0) ? 12'h3f0 : 12'h7f0;
                d0 = 14'($urandom);
                flash_wr(a, d0, 8'h04, !prot(2'(c), a), 1'b0);
                flash_rd(a, 8'h04);
                if (!prot(2'(c), a))
                    `CHK("wp_write", d0, got)
            end
        end
        @(posedge pclk);
        wp <= 2'b11;
        cprot <= 1'b1;
        a = 12'hff0 | 12'($urandom & 32'hc);
        d0 = 14'($urandom);
        flash_wr(a, d0, 8'h04, 1'b1, 1'b0);
        flash_rd(a, 8'h04);
        `CHK("cp_cpu_write", d0, got)
        for (int i = 0; i < 4; i++)
        begin
            @(posedge pclk);
            {want, cprot} <= 2'(i);
            repeat (6) @(posedge pclk);
            `CHK("prog_allow", want & !cprot, prog_allow)
        end
        print_verdict();
    end
endmodule // pfac_tb_top
